// ==== rtl/gpt_pkg.sv ====
// Constants shared by the general purpose timer block.
// Assumes a single 200 MHz system clock and an AXI4-Lite master.
// Contract
// - Idle-halt bit stops timer during Idle
// - Gating works only with internal clock
// - Prescale codes divide by 1/8/64/256
// - Sync bit selects external input resynchronisation
// - Standalone timer decodes four modes
// - B-type syncs external input after prescaler
// - C-type syncs external input before prescaler
// - A C-type timer triggers converter start
// - Only first B and C raise DMA
// - Paired timers decode three modes
// - Timer modes count instruction clock, counter pin
// - Concatenate bit joins B and C
// - C holds upper, B lower; combined readable
// - Combined uses B control, C idle-halt
// - Combined interrupt uses C-type controls only
// - Pairs fixed: first with first, second
// - Combined period is C upper, B lower
// - Combined prescale taken from B-type
// - Combined count lives in paired registers
// - Run bit starts; B run drives pair
// - Concatenate zero keeps two 16-bit timers
package gpt_pkg;
    localparam int          NTMR        = 5;
    localparam logic [7:0]  ADDR_FLAGS  = 8'h50;
    localparam logic [7:0]  ADDR_IRQEN  = 8'h54;
    localparam logic [7:0]  ADDR_PRIO   = 8'h58;
    localparam logic [7:0]  ADDR_CAT0   = 8'h60;
    localparam logic [7:0]  ADDR_CAT1   = 8'h64;
    localparam logic [3:0]  OFS_CTRL    = 4'h0;
    localparam logic [3:0]  OFS_COUNT   = 4'h4;
    localparam logic [3:0]  OFS_PERIOD  = 4'h8;
    localparam int          BIT_RUN     = 15;
    localparam int          BIT_IDLE    = 13;
    localparam int          BIT_GATE    = 6;
    localparam int          BIT_PSHI    = 5;
    localparam int          BIT_PSLO    = 4;
    localparam int          BIT_CAT     = 3;
    localparam int          BIT_SYNC    = 2;
    localparam int          BIT_SRC     = 1;
    localparam logic [15:0] MASK_STD    = 16'hA076;
    localparam logic [15:0] MASK_B      = 16'hA07A;
    localparam logic [15:0] MASK_C      = 16'hA072;
    localparam logic [15:0] PER_RST     = 16'hFFFF;
    localparam logic [7:0]  PS_TC1      = 8'h00;
    localparam logic [7:0]  PS_TC8      = 8'h07;
    localparam logic [7:0]  PS_TC64     = 8'h3F;
    localparam logic [7:0]  PS_TC256    = 8'hFF;
    localparam logic [7:0]  FCY_DIV     = 8'h02;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/gpt_sync2.sv ====
// Two-flop synchroniser for external timer pins.
// Assumes inputs asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module gpt_sync2 #(
    parameter int W = 5
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } gpt_sync_s;

    gpt_sync_s cur_ff, nxt_sync;

    always_comb begin
        nxt_sync.meta   = asyncIn;
        nxt_sync.stable = cur_ff.meta;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_sync;
        end
    end

    assign syncOut = cur_ff.stable;
endmodule // gpt_sync2
`default_nettype wire

// ==== rtl/gpt_prescaler.sv ====
// Input clock prescaler: one output pulse per 1, 8, 64 or 256 input pulses.
// Assumes tickIn is a one-cycle enable on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module gpt_prescaler (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Control
    input  wire logic       clear,
    input  wire logic [1:0] ratioSel,
    // Ticks
    input  wire logic       tickIn,
    output logic            tickOut
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       out;
    } gpt_ps_s;

    gpt_ps_s    cur_ff, nxt_ps;
    logic [7:0] limit;

    always_comb begin
        case (ratioSel)
            2'h0:    limit = gpt_pkg::PS_TC1;
            2'h1:    limit = gpt_pkg::PS_TC8;
            2'h2:    limit = gpt_pkg::PS_TC64;
            2'h3:    limit = gpt_pkg::PS_TC256;
            default: limit = gpt_pkg::PS_TC1;
        endcase
        nxt_ps     = cur_ff;
        nxt_ps.out = 1'b0;
        if (clear) begin
            nxt_ps.cnt = '0;
        end else if (tickIn) begin
            if (cur_ff.cnt >= limit) begin
                nxt_ps.cnt = '0;
                nxt_ps.out = 1'b1;
            end else begin
                nxt_ps.cnt = cur_ff.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ps;
        end
    end

    assign tickOut = cur_ff.out;
endmodule // gpt_prescaler
`default_nettype wire

// ==== rtl/gpt_timers.sv ====
// Five 16-bit timers (standalone, B0, C0, B1, C1) with AXI4-Lite registers.
// Assumes one 200 MHz clock; extIn pins are asynchronous; idleMode is synchronous.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gpt_timers (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Device state and pins
    input  wire logic        idleMode,
    input  wire logic [4:0]  extIn,
    // Events
    output logic [4:0]       irqReq,
    output logic [14:0]      irqPriority,
    output logic             adcTrigger,
    output logic [1:0]       dmaReq
);
    localparam int N = gpt_pkg::NTMR;

    typedef struct packed {
        logic [N-1:0][15:0] ctrl;
        logic [N-1:0][15:0] cnt;
        logic [N-1:0][15:0] per;
        logic [N-1:0][2:0]  prio;
        logic [N-1:0]       flag;
        logic [N-1:0]       irqEn;
        logic [N-1:0]       extPrev;
        logic [N-1:0]       psDly;
        logic [N-1:0]       irq;
        logic               adc;
        logic [1:0]         dma;
        logic [7:0]         div;
        logic               instr;
        logic               awHeld;
        logic               wHeld;
        logic [7:0]         awAddr;
        logic [31:0]        wData;
        logic [3:0]         wStrb;
        logic               awRdy;
        logic               wRdy;
        logic               bValid;
        logic [1:0]         bResp;
        logic               arRdy;
        logic               rValid;
        logic [31:0]        rData;
        logic [1:0]         rResp;
    } gpt_state_s;

    gpt_state_s          cur_ff;
    gpt_state_s          nxt_st;
    logic [N-1:0]        extSync;
    logic [N-1:0]        psIn;
    logic [N-1:0]        psClr;
    logic [N-1:0][1:0]   psSel;
    logic [N-1:0]        psOut;

    gpt_sync2 #(.W(N)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (extIn),
        .syncOut (extSync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_ps
            gpt_prescaler u_ps (
                .sys_clk  (sys_clk),
                .rst      (rst),
                .clear    (psClr[gi]),
                .ratioSel (psSel[gi]),
                .tickIn   (psIn[gi]),
                .tickOut  (psOut[gi])
            );
        end
    endgenerate

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Index of the B-type timer owning timer k's pair
    function automatic int bOf(input int k);
        bOf = (k < 3) ? 1 : 3;
    endfunction

    always_comb begin
        logic [N-1:0]  run;
        logic [N-1:0]  gated;
        logic [N-1:0]  tick;
        logic [N-1:0]  evt;
        logic [N-1:0]  rise;
        logic [N-1:0]  fall;
        logic [N-1:0]  catOf;
        logic [N-1:0]  clr;
        logic [15:0]   ec;
        logic [31:0]   c32;
        logic [31:0]   p32;
        logic [31:0]   rd;
        logic [1:0]    rsp;
        logic [7:0]    a;
        int            e;
        int            b;
        int            c;
        run    = '0;
        gated  = '0;
        tick   = '0;
        evt    = '0;
        catOf  = '0;
        clr    = '0;
        ec     = '0;
        c32    = '0;
        p32    = '0;
        rd     = '0;
        rsp    = gpt_pkg::RESP_OKAY;
        a      = '0;
        e      = 0;
        b      = 0;
        c      = 0;
        nxt_st = cur_ff;
        rise   = extSync & ~cur_ff.extPrev;
        fall   = ~extSync & cur_ff.extPrev;
        nxt_st.extPrev = extSync;

        // Instruction clock enable
        nxt_st.instr = 1'b0;
        if (cur_ff.div >= gpt_pkg::FCY_DIV - 8'h01) begin
            nxt_st.div   = '0;
            nxt_st.instr = 1'b1;
        end else begin
            nxt_st.div = cur_ff.div + 8'h01;
        end

        // Per-timer clock selection; a joined pair takes B's control and B's pin
        for (int k = 0; k < N; k++) begin
            b = bOf(k);
            c = b + 1;
            catOf[k] = (k != 0) && cur_ff.ctrl[b][gpt_pkg::BIT_CAT];
            ec = catOf[k] ? cur_ff.ctrl[b] : cur_ff.ctrl[k];
            e  = catOf[k] ? b : k;
            run[k] = ec[gpt_pkg::BIT_RUN] &
                     ~(idleMode & (catOf[k] ? cur_ff.ctrl[c][gpt_pkg::BIT_IDLE]
                                            : cur_ff.ctrl[k][gpt_pkg::BIT_IDLE]));
            gated[k] = ~ec[gpt_pkg::BIT_SRC] & ec[gpt_pkg::BIT_GATE];
            psIn[k]  = ec[gpt_pkg::BIT_SRC] ? rise[e]
                                            : (cur_ff.instr & (~gated[k] | extSync[e]));
            psClr[k] = ~run[k];
            psSel[k] = ec[gpt_pkg::BIT_PSHI:gpt_pkg::BIT_PSLO];
            nxt_st.psDly[k] = psOut[k];
            // Retime stage after the prescaler: standalone sync mode and B-type counters
            if (ec[gpt_pkg::BIT_SRC] &&
                ((k == 0) ? ec[gpt_pkg::BIT_SYNC] : (k == 1 || k == 3))) begin
                tick[k] = cur_ff.psDly[k];
            end else begin
                tick[k] = psOut[k];
            end
        end

        // Independent 16-bit counting
        for (int k = 0; k < N; k++) begin
            if (!catOf[k] && run[k]) begin
                if (tick[k]) begin
                    if (cur_ff.cnt[k] == cur_ff.per[k]) begin
                        nxt_st.cnt[k] = '0;
                        evt[k] = ~gated[k];
                    end else begin
                        nxt_st.cnt[k] = cur_ff.cnt[k] + 16'h0001;
                    end
                end
                if (gated[k] && fall[k]) begin
                    evt[k] = 1'b1;
                end
            end
        end

        // Joined 32-bit counting; the event lands on the C-type timer only
        for (int p = 0; p < 2; p++) begin
            b = 1 + 2 * p;
            c = b + 1;
            c32 = {cur_ff.cnt[c], cur_ff.cnt[b]};
            p32 = {cur_ff.per[c], cur_ff.per[b]};
            if (catOf[b] && run[b]) begin
                if (tick[b]) begin
                    if (c32 == p32) begin
                        c32 = '0;
                        evt[c] = ~gated[b];
                    end else begin
                        c32 = c32 + 32'h0000_0001;
                    end
                end
                if (gated[b] && fall[b]) begin
                    evt[c] = 1'b1;
                end
                nxt_st.cnt[c] = c32[31:16];
                nxt_st.cnt[b] = c32[15:0];
            end
        end

        // Write channel
        if (s_axi_awvalid && cur_ff.awRdy) begin
            nxt_st.awHeld = 1'b1;
            nxt_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && cur_ff.wRdy) begin
            nxt_st.wHeld = 1'b1;
            nxt_st.wData = s_axi_wdata;
            nxt_st.wStrb = s_axi_wstrb;
        end
        if (cur_ff.bValid && s_axi_bready) begin
            nxt_st.bValid = 1'b0;
        end
        if (cur_ff.awHeld && cur_ff.wHeld && !cur_ff.bValid) begin
            a = {cur_ff.awAddr[7:2], 2'b00};
            nxt_st.awHeld = 1'b0;
            nxt_st.wHeld  = 1'b0;
            nxt_st.bValid = 1'b1;
            if (a < gpt_pkg::ADDR_FLAGS) begin
                e = int'(a[6:4]);
                case (a[3:0])
                    gpt_pkg::OFS_CTRL: begin
                        nxt_st.ctrl[e] = merge16(cur_ff.ctrl[e], cur_ff.wData, cur_ff.wStrb) &
                                         ((e == 0) ? gpt_pkg::MASK_STD :
                                          (e == 1 || e == 3) ? gpt_pkg::MASK_B
                                                             : gpt_pkg::MASK_C);
                    end
                    gpt_pkg::OFS_COUNT: begin
                        nxt_st.cnt[e] = merge16(cur_ff.cnt[e], cur_ff.wData, cur_ff.wStrb);
                    end
                    gpt_pkg::OFS_PERIOD: begin
                        nxt_st.per[e] = merge16(cur_ff.per[e], cur_ff.wData, cur_ff.wStrb);
                    end
                    default: rsp = gpt_pkg::RESP_SLVERR;
                endcase
            end else if (a == gpt_pkg::ADDR_FLAGS) begin
                clr = cur_ff.wStrb[0] ? cur_ff.wData[N-1:0] : '0;
            end else if (a == gpt_pkg::ADDR_IRQEN) begin
                if (cur_ff.wStrb[0]) begin
                    nxt_st.irqEn = cur_ff.wData[N-1:0];
                end
            end else if (a == gpt_pkg::ADDR_PRIO) begin
                nxt_st.prio = 15'(merge16({1'b0, cur_ff.prio}, cur_ff.wData, cur_ff.wStrb));
            end else if (a != gpt_pkg::ADDR_CAT0 && a != gpt_pkg::ADDR_CAT1) begin
                rsp = gpt_pkg::RESP_SLVERR;
            end
            nxt_st.bResp = rsp;
        end

        // Read channel
        if (cur_ff.rValid && s_axi_rready) begin
            nxt_st.rValid = 1'b0;
        end
        if (s_axi_arvalid && cur_ff.arRdy) begin
            a   = {s_axi_araddr[7:2], 2'b00};
            rsp = gpt_pkg::RESP_OKAY;
            if (a < gpt_pkg::ADDR_FLAGS) begin
                e = int'(a[6:4]);
                case (a[3:0])
                    gpt_pkg::OFS_CTRL:   rd = {16'h0000, cur_ff.ctrl[e]};
                    gpt_pkg::OFS_COUNT:  rd = {16'h0000, cur_ff.cnt[e]};
                    gpt_pkg::OFS_PERIOD: rd = {16'h0000, cur_ff.per[e]};
                    default:             rsp = gpt_pkg::RESP_SLVERR;
                endcase
            end else if (a == gpt_pkg::ADDR_FLAGS) begin
                rd = {27'h0, cur_ff.flag};
            end else if (a == gpt_pkg::ADDR_IRQEN) begin
                rd = {27'h0, cur_ff.irqEn};
            end else if (a == gpt_pkg::ADDR_PRIO) begin
                rd = {17'h0, cur_ff.prio};
            end else if (a == gpt_pkg::ADDR_CAT0) begin
                rd = {cur_ff.cnt[2], cur_ff.cnt[1]};
            end else if (a == gpt_pkg::ADDR_CAT1) begin
                rd = {cur_ff.cnt[4], cur_ff.cnt[3]};
            end else begin
                rsp = gpt_pkg::RESP_SLVERR;
            end
            nxt_st.rValid = 1'b1;
            nxt_st.rData  = rd;
            nxt_st.rResp  = rsp;
        end

        // Readies are registered so every bus output comes from a flop
        nxt_st.awRdy = ~nxt_st.awHeld & ~nxt_st.bValid;
        nxt_st.wRdy  = ~nxt_st.wHeld & ~nxt_st.bValid;
        nxt_st.arRdy = ~nxt_st.rValid;

        // A new event beats a simultaneous software clear
        nxt_st.flag = (cur_ff.flag & ~clr) | evt;
        nxt_st.irq  = nxt_st.flag & nxt_st.irqEn;
        nxt_st.adc  = evt[2];
        nxt_st.dma  = {evt[2], evt[1]};
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur_ff     <= '0;
            cur_ff.per <= {N{gpt_pkg::PER_RST}};
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign s_axi_awready = cur_ff.awRdy;
    assign s_axi_wready  = cur_ff.wRdy;
    assign s_axi_bvalid  = cur_ff.bValid;
    assign s_axi_bresp   = cur_ff.bResp;
    assign s_axi_arready = cur_ff.arRdy;
    assign s_axi_rvalid  = cur_ff.rValid;
    assign s_axi_rdata   = cur_ff.rData;
    assign s_axi_rresp   = cur_ff.rResp;
    assign irqReq        = cur_ff.irq;
    assign irqPriority   = cur_ff.prio;
    assign adcTrigger    = cur_ff.adc;
    assign dmaReq        = cur_ff.dma;
endmodule // gpt_timers
`default_nettype wire

// ==== verification/gpt_timers_checker.sv ====
// Checker for the timer block: bus handshakes and event outputs.
// Sees only the ports of gpt_timers and is attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module gpt_timers_checker (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Events
    input wire logic [14:0] irqPriority,
    input wire logic        adcTrigger,
    input wire logic [1:0]  dmaReq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Both halves are held for one cycle before the write lands, so bvalid is two edges on
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response missing");
    AST_WR_REFUSED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_WR_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read data missing");
    AST_RD_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
        && s_axi_arready) else $error("read channel not released");
    AST_ERR_DATA: assert property (s_axi_rvalid && s_axi_rresp == gpt_pkg::RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("error read carries data");
    AST_ADC_PULSE: assert property (adcTrigger |=> !adcTrigger)
        else $error("converter trigger longer than one cycle");
    AST_DMA_PAIR: assert property ((adcTrigger || dmaReq[1]) |-> adcTrigger && dmaReq[1])
        else $error("upper request not tied to converter trigger");
    AST_DMA_PULSE: assert property (dmaReq[0] |=> !dmaReq[0])
        else $error("lower request longer than one cycle");
    AST_PRIO_WRITE: assert property (!$stable(irqPriority) |-> $rose(s_axi_bvalid))
        else $error("priority changed without a write");
endmodule // gpt_timers_checker

bind gpt_timers gpt_timers_checker gpt_timers_checker_inst (
    .sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irqPriority, .adcTrigger, .dmaReq
);
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the timer block: register map, prescale, pairing, events.
// Drives every port itself as an AXI4-Lite master; pins toggle slowly.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin failCount++; \
    $display("ERROR at %0t got %0h expected %0h", $time, (g), (e)); end end
module tb;
    logic        sys_clk, rst, idleMode, adcTrigger;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, e;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, dmaReq;
    logic [4:0]  extIn, irqReq;
    logic [14:0] irqPriority;
    logic [2:0]  evt;
    logic [15:0] msk [5];
    int          dv [4];
    int          testsRun, failCount, k, n;

    assign evt = {adcTrigger, dmaReq};

    gpt_timers gpt_timers_inst (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .idleMode, .extIn, .irqReq, .irqPriority,
        .adcTrigger, .dmaReq);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Address and data go out together; each is dropped at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            aw |= s_axi_awready;
            w |= s_axi_wready;
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] x,
                      input logic [1:0] rx = gpt_pkg::RESP_OKAY);
        rd(a);
        `CHK({r, d}, {rx, x})
    endtask

    // Cycles between two successive pulses of one event line
    task automatic gap(input int s, output int g);
        g = 0;
        do @(posedge sys_clk); while (!evt[s]);
        do begin @(posedge sys_clk); g++; end while (!evt[s]);
    endtask

    task automatic endOfTest();
        $display("Comparisons %0d, mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        failCount++;
        endOfTest();
    end

    initial begin
        {rst, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
        {idleMode, extIn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        msk = '{gpt_pkg::MASK_STD, gpt_pkg::MASK_B, gpt_pkg::MASK_C, gpt_pkg::MASK_B,
                gpt_pkg::MASK_C};
        dv = '{1, 8, 64, 256};
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);

        for (k = 0; k < 5; k++) begin
            rc(8'(k * 16), 0);
            rc(8'(k * 16 + 4), 0);
            rc(8'(k * 16 + 8), 32'hFFFF);
        end
        for (k = 0; k < 5; k++) begin
            wr(8'(k * 16), 32'hFFFF);
            rc(8'(k * 16), {16'h0, msk[k]});
            wr(8'(k * 16), 0);
        end
        wr(8'h58, 32'h7FFF);
        `CHK(irqPriority, 15'h7FFF)
        rc(8'h58, 32'h7FFF);
        wr(8'h58, 0);
        rc(8'h70, 0, gpt_pkg::RESP_SLVERR);
        rc(8'h0C, 0, gpt_pkg::RESP_SLVERR);
        wr(8'h70, 1);
        `CHK(r, gpt_pkg::RESP_SLVERR)
        $display("register map test done");

        // Period 1 gives two ticks per event; a tick is two system clocks times the prescale ratio
        for (k = 1; k < 3; k++) begin
            wr(8'(k * 16 + 8), 1);
            wr(8'(k * 16 + 4), 0);
            for (int c = 0; c < 4; c++) begin
                wr(8'(k * 16), 32'h8000 | (c << 4));
                gap(k == 1 ? 0 : 2, n);
                `CHK(n, 4 * dv[c])
                wr(8'(k * 16), 0);
            end
            wr(8'(k * 16 + 8), 32'hFFFF);
        end
        $display("prescale test done");

        // Rows: sync counter, async counter, then each paired timer with gate bit set
        for (int i = 0; i < 6; i++) begin
            k = (i < 2) ? 0 : i - 1;
            wr(8'(k * 16 + 4), 0);
            wr(8'(k * 16), (i == 1) ? 32'h8042 : 32'h8046);
            repeat (5) begin
                extIn[k] <= 1'b1;
                repeat (8) @(posedge sys_clk);
                extIn[k] <= 1'b0;
                repeat (8) @(posedge sys_clk);
            end
            wr(8'(k * 16), 0);
            rc(8'(k * 16 + 4), 5);
        end
        $display("external count test done");

        // Upper period word decides whether the joined pair reaches its period
        wr(8'h54, 32'h06);
        for (int cp = 1; cp < 3; cp++) begin
            wr(8'h10, 32'h0008);
            wr(8'h50, 32'h1F);
            wr(8'h14, 32'hFFF0);
            wr(8'h24, 1);
            wr(8'h18, 32'hFFF8);
            wr(8'h28, cp);
            wr(8'h20, 32'h0030);
            wr(8'h10, 32'h8008);
            e = 0;
            repeat (60) begin
                @(posedge sys_clk);
                e[1:0] |= irqReq[2:1];
            end
            `CHK(e[1:0], (cp == 1) ? 2'b10 : 2'b00)
            wr(8'h10, 32'h0008);
            rd(8'h14);
            e[15:0] = d[15:0];
            rd(8'h24);
            e[31:16] = d[15:0];
            `CHK(e[31:16], (cp == 1) ? 16'h0 : 16'h2)
            rc(8'h60, e);
        end
        wr(8'h10, 0);
        $display("joined pair test done");

        for (int h = 0; h < 2; h++) begin
            wr(8'h00, h ? 32'hA000 : 32'h8000);
            idleMode <= 1'b1;
            rd(8'h04);
            e = d;
            repeat (20) @(posedge sys_clk);
            rd(8'h04);
            `CHK(d == e, h == 1)
            idleMode <= 1'b0;
            wr(8'h00, 0);
        end
        $display("idle test done");

        wr(8'h50, 32'h1F);
        wr(8'h04, 0);
        wr(8'h00, 32'h8040);
        repeat (20) @(posedge sys_clk);
        rc(8'h04, 0);
        extIn[0] <= 1'b1;
        repeat (40) @(posedge sys_clk);
        extIn[0] <= 1'b0;
        repeat (10) @(posedge sys_clk);
        wr(8'h00, 0);
        rd(8'h04);
        `CHK(d != 0, 1'b1)
        rc(8'h50, 1);
        $display("gated test done");

        wr(8'h38, 0);
        wr(8'h48, 0);
        // Counts left by the pin test would need a full wrap to meet a zero period
        wr(8'h34, 0);
        wr(8'h44, 0);
        wr(8'h54, 32'h18);
        wr(8'h30, 32'h8000);
        wr(8'h40, 32'h8000);
        e = 0;
        repeat (40) begin
            @(posedge sys_clk);
            e[2:0] |= evt;
            e[4:3] |= irqReq[4:3];
        end
        `CHK(e[4:0], 5'h18)
        $display("second pair test done");
        endOfTest();
    end
endmodule // tb
`default_nettype wire
